// *** verilog/nvm_consts.svh ***
/*
  Offsets, field positions, reset values and timing figures of the
  data store access controller.
  Assumes a 12-bit APB byte address and a 20 MHz pclk.
*/
`ifndef NVM_CONSTS_SVH
`define NVM_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define NVM_OFS_BUFFER     12'h000
`define NVM_OFS_INDEX_LO   12'h004
`define NVM_OFS_INDEX_HI   12'h008
`define NVM_OFS_CONTROL    12'h00C
`define NVM_OFS_UNLOCK     12'h010
`define NVM_OFS_FLAGS      12'h014
`define NVM_OFS_MASK       12'h018

// ****************************************
// control and flag field positions
// ****************************************
`define NVM_B_CODE_SPACE   7
`define NVM_B_FUSE_SPACE   6
`define NVM_B_ABORT        3
`define NVM_B_PERMIT       2
`define NVM_B_PROG_GO      1
`define NVM_B_READ_GO      0
`define NVM_B_DONE_FLAG    6

// ****************************************
// values and sizes
// ****************************************
`define NVM_DEPTH          1024
`define NVM_ERASED         8'hFF
`define NVM_KEY_FIRST      8'h55
`define NVM_KEY_SECOND     8'hAA
`define NVM_RST_BYTE       8'h00
`define NVM_PCLK_NS        50
`define NVM_ERASE_TIME_NS  2000000
`define NVM_PROG_TIME_NS   2000000
`define NVM_CNT_W          16

`endif

// *** verilog/nvm_pkg.sv ***
/*
  Types of the data store access controller.
  Assumes nvm_consts.svh is on the include path.
*/
package nvm_pkg;

  // target space of an access
  typedef enum logic [1:0] {
    NVM_SP_DATA = 2'h0,
    NVM_SP_CODE = 2'h1,
    NVM_SP_FUSE = 2'h2
  } nvm_space_t;

  // request to program or fuse space outside this block
  typedef struct packed {
    logic       valid;
    logic       write;
    nvm_space_t space;
    logic [9:0] addr;
    logic [7:0] data;
  } nvm_ext_req_t;

  typedef struct packed {
    logic code_space_select;
    logic fuse_space_select;
    logic program_abort_flag;
    logic program_permit;
    logic prog_go;
    logic read_go;
  } nvm_ctrl_t;

  typedef enum logic [2:0] {
    NVM_KEY_IDLE  = 3'h1,
    NVM_KEY_HALF  = 3'h2,
    NVM_KEY_ARMED = 3'h4
  } nvm_key_t;

  typedef enum logic [2:0] {
    NVM_TM_IDLE  = 3'h1,
    NVM_TM_ERASE = 3'h2,
    NVM_TM_PROG  = 3'h4
  } nvm_tm_t;

endpackage : nvm_pkg

// *** verilog/nvm_self_timer.sv ***
/*
  Self-timer of one erase/write cycle: an erase phase, then a program phase.
  Assumes start comes only while idle; abort ends a cycle at once.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nvm_consts.svh"

module nvm_self_timer #(
  parameter int ERASE_CYCLES = 2,
  parameter int PROG_CYCLES  = 2
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      erase_done,
  output logic      prog_done
);

  localparam int CW = `NVM_CNT_W;

  nvm_pkg::nvm_tm_t state;
  nvm_pkg::nvm_tm_t next_state;
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    next_cnt;

  // ****************************************
  // phase sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    erase_done = 1'b0;
    prog_done  = 1'b0;
    case (state)
      nvm_pkg::NVM_TM_IDLE: begin
        if (start) begin
          next_state = nvm_pkg::NVM_TM_ERASE;
          next_cnt   = CW'(ERASE_CYCLES - 1);
        end
      end
      nvm_pkg::NVM_TM_ERASE: begin
        if (abort) begin
          next_state = nvm_pkg::NVM_TM_IDLE;
        end else if (cnt == '0) begin
          erase_done = 1'b1;
          next_state = nvm_pkg::NVM_TM_PROG;
          next_cnt   = CW'(PROG_CYCLES - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      nvm_pkg::NVM_TM_PROG: begin
        if (abort) begin
          next_state = nvm_pkg::NVM_TM_IDLE;
        end else if (cnt == '0) begin
          prog_done  = 1'b1;
          next_state = nvm_pkg::NVM_TM_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = nvm_pkg::NVM_TM_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= nvm_pkg::NVM_TM_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign busy = (state != nvm_pkg::NVM_TM_IDLE);

  a_erase_loads_len: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy) |=> (state == nvm_pkg::NVM_TM_ERASE) && (cnt == CW'(ERASE_CYCLES - 1)))
    else $error("erase phase did not load its length");
  a_prog_follows: assert property (@(posedge pclk) disable iff (!presetn)
    erase_done |=> (state == nvm_pkg::NVM_TM_PROG) && (cnt == CW'(PROG_CYCLES - 1)))
    else $error("program phase did not follow erase");

endmodule : nvm_self_timer

`default_nettype wire

// *** verilog/nvm_access_ctrl.sv ***
/*
  Byte access controller of a 1024-byte data store, with an APB slave,
  unlock port, self-timed erase/write and a done interrupt.
  Assumes program and fuse space answer ext_rdata combinationally
  from the registered ext_req address, on the same pclk.
*/
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_consts.svh"

// Contract
// - byte reads and writes through the buffer at the two-register index
// - only the two low bits of the high index take part in access
// - index is ten bits, locations 000h to 3FFh
// - a byte write erases the location first, then programs it (data store only; program and fuse space get one write request at the end)
// - erase/write length comes from the internal self-timer
// - code space select 0 targets the data store, 1 program memory
// - fuse space select 1 targets configuration, else code select decides
// - writes need program permit, which is 0 after power-up
// - abort flag marks a write cut by reset or started wrongly (every idle start and a warm reset mid-write set it; completion, presetn or writing 0 clear it)
// - software can only set program start; hardware clears it when done
// - done flag at bit 6 of the flag register, cleared by software
// - read start begins a read; hardware clears it when complete
// - read start cannot be set while code space select is 1
// - unlock port stores nothing and reads as zero
module nvm_access_ctrl #(
  parameter int ERASE_CYCLES =
    (`NVM_ERASE_TIME_NS + `NVM_PCLK_NS - 1) / `NVM_PCLK_NS,
  parameter int PROG_CYCLES  =
    (`NVM_PROG_TIME_NS + `NVM_PCLK_NS - 1) / `NVM_PCLK_NS
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // interrupt
  output logic                       irq,
  // warm reset request pin
  input  wire logic                  warm_rst_req,
  // program and fuse space
  output var nvm_pkg::nvm_ext_req_t  ext_req,
  input  wire logic [7:0]            ext_rdata
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]            mem [0:`NVM_DEPTH-1];
  logic [7:0]            buffer_q,   next_buffer;
  logic [7:0]            index_lo,   next_index_lo;
  logic [7:0]            index_hi,   next_index_hi;
  nvm_pkg::nvm_ctrl_t    ctrl,       next_ctrl;
  nvm_pkg::nvm_key_t     key,        next_key;
  logic [7:0]            flags,      next_flags;
  logic [7:0]            mask,       next_mask;
  logic                  rd_wait,    next_rd_wait;
  logic [9:0]            op_addr,    next_op_addr;
  logic [7:0]            op_data,    next_op_data;
  nvm_pkg::nvm_space_t   op_space,   next_op_space;
  nvm_pkg::nvm_ext_req_t next_ext_req;
  logic                  next_irq;
  logic [31:0]           next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;
  logic                  rst_meta;
  logic                  rst_sync;
  logic                  tm_start;
  logic                  tm_abort;
  logic                  tm_busy;
  logic                  erase_done;
  logic                  prog_done;
  logic                  wr_acc;
  logic [9:0]            index;
  logic [7:0]            ctrl_byte;
  logic [7:0]            rd_byte;
  logic                  mapped;
  logic                  new_css;

  // ****************************************
  // helpers
  // ****************************************
  function automatic nvm_pkg::nvm_space_t space_of(input logic css,
                                                   input logic fss);
    if (fss) begin
      space_of = nvm_pkg::NVM_SP_FUSE;
    end else if (css) begin
      space_of = nvm_pkg::NVM_SP_CODE;
    end else begin
      space_of = nvm_pkg::NVM_SP_DATA;
    end
  endfunction : space_of

  assign wr_acc = psel && penable && pready && pwrite;
  assign index  = {index_hi[1:0], index_lo};
  assign new_css = pwdata[`NVM_B_CODE_SPACE];

  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[`NVM_B_CODE_SPACE] = ctrl.code_space_select;
    ctrl_byte[`NVM_B_FUSE_SPACE] = ctrl.fuse_space_select;
    ctrl_byte[`NVM_B_ABORT]      = ctrl.program_abort_flag;
    ctrl_byte[`NVM_B_PERMIT]     = ctrl.program_permit;
    ctrl_byte[`NVM_B_PROG_GO]    = ctrl.prog_go;
    ctrl_byte[`NVM_B_READ_GO]    = ctrl.read_go;
  end

  // ****************************************
  // self-timer
  // ****************************************
  nvm_self_timer #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .PROG_CYCLES  (PROG_CYCLES)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (tm_start),
    .abort      (tm_abort),
    .busy       (tm_busy),
    .erase_done (erase_done),
    .prog_done  (prog_done)
  );

  // ****************************************
  // apb read path
  // ****************************************
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `NVM_OFS_BUFFER:   rd_byte = buffer_q;
      `NVM_OFS_INDEX_LO: rd_byte = index_lo;
      `NVM_OFS_INDEX_HI: rd_byte = index_hi;
      `NVM_OFS_CONTROL:  rd_byte = ctrl_byte;
      `NVM_OFS_UNLOCK:   rd_byte = 8'h00;
      `NVM_OFS_FLAGS:    rd_byte = flags;
      `NVM_OFS_MASK:     rd_byte = mask;
      default:           mapped  = 1'b0;
    endcase
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    next_prdata  = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // warm reset synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= warm_rst_req;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // control core
  // ****************************************
  always_comb begin
    next_buffer   = buffer_q;
    next_index_lo = index_lo;
    next_index_hi = index_hi;
    next_ctrl     = ctrl;
    next_key      = key;
    next_flags    = flags;
    next_mask     = mask;
    next_rd_wait  = rd_wait;
    next_op_addr  = op_addr;
    next_op_data  = op_data;
    next_op_space = op_space;
    next_ext_req  = '0;
    tm_start      = 1'b0;
    tm_abort      = 1'b0;

    // software writes
    if (wr_acc) begin
      next_key = nvm_pkg::NVM_KEY_IDLE;
      case (paddr)
        `NVM_OFS_BUFFER:   next_buffer   = pwdata[7:0];
        `NVM_OFS_INDEX_LO: next_index_lo = pwdata[7:0];
        `NVM_OFS_INDEX_HI: next_index_hi = pwdata[7:0];
        `NVM_OFS_CONTROL: begin
          next_ctrl.code_space_select = new_css;
          next_ctrl.fuse_space_select = pwdata[`NVM_B_FUSE_SPACE];
          next_ctrl.program_permit    = pwdata[`NVM_B_PERMIT];
          if (!pwdata[`NVM_B_ABORT]) begin
            next_ctrl.program_abort_flag = 1'b0;
          end
          if (pwdata[`NVM_B_READ_GO] && !new_css) begin
            next_ctrl.read_go = 1'b1;
          end
          if (pwdata[`NVM_B_PROG_GO] && !ctrl.prog_go && !tm_busy) begin
            if (key == nvm_pkg::NVM_KEY_ARMED &&
                pwdata[`NVM_B_PERMIT]) begin
              next_ctrl.prog_go            = 1'b1;
              next_ctrl.program_abort_flag = 1'b1;
              tm_start                     = 1'b1;
              next_op_addr  = index;
              next_op_data  = buffer_q;
              next_op_space = space_of(new_css, pwdata[`NVM_B_FUSE_SPACE]);
            end else begin
              next_ctrl.program_abort_flag = 1'b1;
            end
          end
        end
        `NVM_OFS_UNLOCK: begin
          if (pwdata[7:0] == `NVM_KEY_FIRST) begin
            next_key = nvm_pkg::NVM_KEY_HALF;
          end else if (pwdata[7:0] == `NVM_KEY_SECOND &&
                       key == nvm_pkg::NVM_KEY_HALF) begin
            next_key = nvm_pkg::NVM_KEY_ARMED;
          end
        end
        `NVM_OFS_FLAGS: next_flags = flags & ~pwdata[7:0];
        `NVM_OFS_MASK:  next_mask  = pwdata[7:0];
        default: begin
        end
      endcase
    end

    // read: the data store answers at once, fuse space one cycle later
    if (ctrl.read_go) begin
      if (space_of(ctrl.code_space_select, ctrl.fuse_space_select) ==
          nvm_pkg::NVM_SP_FUSE && !rd_wait) begin
        next_rd_wait       = 1'b1;
        next_ext_req.valid = 1'b1;
        next_ext_req.space = nvm_pkg::NVM_SP_FUSE;
        next_ext_req.addr  = index;
      end else begin
        next_buffer       = rd_wait ? ext_rdata : mem[index];
        next_rd_wait      = 1'b0;
        next_ctrl.read_go = 1'b0;
      end
    end

    // end of a write cycle
    if (prog_done) begin
      next_ctrl.prog_go            = 1'b0;
      next_ctrl.program_abort_flag = 1'b0;
      next_flags[`NVM_B_DONE_FLAG] = 1'b1;
      if (op_space != nvm_pkg::NVM_SP_DATA) begin
        next_ext_req.valid = 1'b1;
        next_ext_req.write = 1'b1;
        next_ext_req.space = op_space;
        next_ext_req.addr  = op_addr;
        next_ext_req.data  = op_data;
      end
    end

    // warm reset cuts a running cycle short
    if (rst_sync && tm_busy) begin
      tm_abort                     = 1'b1;
      next_ctrl.prog_go            = 1'b0;
      next_ctrl.program_abort_flag = 1'b1;
    end

    next_irq = |(next_flags & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_q <= `NVM_RST_BYTE;
      index_lo <= `NVM_RST_BYTE;
      index_hi <= `NVM_RST_BYTE;
      ctrl     <= '0;
      key      <= nvm_pkg::NVM_KEY_IDLE;
      flags    <= `NVM_RST_BYTE;
      mask     <= `NVM_RST_BYTE;
      rd_wait  <= 1'b0;
      op_addr  <= 10'h000;
      op_data  <= `NVM_RST_BYTE;
      op_space <= nvm_pkg::NVM_SP_DATA;
      ext_req  <= '0;
      irq      <= 1'b0;
    end else begin
      buffer_q <= next_buffer;
      index_lo <= next_index_lo;
      index_hi <= next_index_hi;
      ctrl     <= next_ctrl;
      key      <= next_key;
      flags    <= next_flags;
      mask     <= next_mask;
      rd_wait  <= next_rd_wait;
      op_addr  <= next_op_addr;
      op_data  <= next_op_data;
      op_space <= next_op_space;
      ext_req  <= next_ext_req;
      irq      <= next_irq;
    end
  end

  // ****************************************
  // store array: erase to all ones, then program
  // ****************************************
  always_ff @(posedge pclk) begin
    if (op_space == nvm_pkg::NVM_SP_DATA) begin
      if (erase_done) begin
        mem[op_addr] <= `NVM_ERASED;
      end else if (prog_done) begin
        mem[op_addr] <= op_data;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_read_go_clears: assert property (
    (ctrl.read_go && !rd_wait && !ctrl.fuse_space_select) |=> !ctrl.read_go)
    else $error("read start not cleared after one cycle");
  a_read_fills_buf: assert property (
    (ctrl.read_go && !ctrl.fuse_space_select) |=> (buffer_q == $past(mem[index])))
    else $error("read byte not in buffer");
  a_code_blocks_rd: assert property (
    (wr_acc && paddr == `NVM_OFS_CONTROL && new_css && !ctrl.read_go) |=> !ctrl.read_go)
    else $error("read start set in code space");
  a_unlock_reads_0: assert property (
    (psel && !penable && !pwrite && paddr == `NVM_OFS_UNLOCK) |=> (prdata == 32'h00000000))
    else $error("unlock port read not zero");
  a_start_needs_key: assert property (
    tm_start |-> (key == nvm_pkg::NVM_KEY_ARMED) && pwdata[`NVM_B_PERMIT])
    else $error("write started without key or permit");
  a_bad_start_abort: assert property (
    (wr_acc && paddr == `NVM_OFS_CONTROL && pwdata[`NVM_B_PROG_GO] && !tm_busy &&
     !ctrl.prog_go && key != nvm_pkg::NVM_KEY_ARMED) |=> ctrl.program_abort_flag && !tm_busy)
    else $error("wrong start not flagged");
  a_done_sets_flag: assert property (
    prog_done |=> flags[`NVM_B_DONE_FLAG] && !ctrl.prog_go && !ctrl.program_abort_flag)
    else $error("completion not reported");
  a_prog_go_holds: assert property (
    (ctrl.prog_go && !prog_done && !(rst_sync && tm_busy)) |=> ctrl.prog_go)
    else $error("program start dropped early");
  a_irq_follows: assert property (
    (prog_done && next_mask[`NVM_B_DONE_FLAG]) |=> irq)
    else $error("interrupt level wrong");

endmodule : nvm_access_ctrl

`default_nettype wire

// *** sim/nvm_access_ctrl_tb_top.sv ***
/*
  Self-checking testbench of the data store access controller: APB driver,
  read monitor with a queue of expected answers, and the scenarios.
  Assumes nvm_consts.svh on the include path and the design compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nvm_consts.svh"

module nvm_access_ctrl_tb_top;
  localparam logic [11:0] A_BUF = `NVM_OFS_BUFFER;
  localparam logic [11:0] A_LO  = `NVM_OFS_INDEX_LO;
  localparam logic [11:0] A_HI  = `NVM_OFS_INDEX_HI;
  localparam logic [11:0] A_CTL = `NVM_OFS_CONTROL;
  localparam logic [11:0] A_KEY = `NVM_OFS_UNLOCK;
  localparam logic [11:0] A_FLG = `NVM_OFS_FLAGS;
  localparam logic [11:0] A_MSK = `NVM_OFS_MASK;

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic                  warm_rst_req;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic [31:0]           rd;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic [7:0]            ext_rdata;
  logic [7:0]            ext_b;
  logic [7:0]            d;
  logic [9:0]            a;
  nvm_pkg::nvm_ext_req_t ext_req;
  logic [7:0]            mem [1024];
  logic [33:0]           exp_q [$];
  logic [33:0]           e;
  logic [21:0]           ext_q [$];
  logic [21:0]           ext_e;
  int                    bad_count;
  int                    comparisons;
  int                    cycles;

  nvm_access_ctrl #(
    .ERASE_CYCLES(8),
    .PROG_CYCLES (8)
  ) dut (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .irq         (irq),
    .warm_rst_req(warm_rst_req),
    .ext_req     (ext_req),
    .ext_rdata   (ext_rdata)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // compare, bus and closing tasks
  // ****************************************
  task automatic chk_data(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_data

  task automatic chk_bit(input string nm, input logic ex, input logic got);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_bit

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // one transfer; the expectation is queued before the setup cycle
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] dt,
                     input logic chk);
    exp_q.push_back({chk, ad > A_MSK, dt});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt, 1'b1);
  endtask : wr

  task automatic rdc(input logic [11:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, ex, 1'b1);
  endtask : rdc

  task automatic keys;
    wr(A_KEY, {24'h0, `NVM_KEY_FIRST});
    wr(A_KEY, {24'h0, `NVM_KEY_SECOND});
  endtask : keys

  // upper six bits of the high index are random and must not matter
  task automatic point(input logic [9:0] ad);
    wr(A_LO, {24'h0, ad[7:0]});
    wr(A_HI, {24'h0, 6'($urandom), ad[9:8]});
  endtask : point

  task automatic prog(input logic [9:0] ad, input logic [7:0] dt, input logic [7:0] c);
    point(ad);
    wr(A_BUF, {24'h0, dt});
    keys();
    wr(A_CTL, {24'h0, c});
  endtask : prog

  // a hang is ended by the cycle ceiling
  task automatic wait_done;
    do begin
      apb(1'b0, A_CTL, 32'h0, 1'b0);
    end while (rd[1] !== 1'b0);
  endtask : wait_done

  task automatic fetch(input logic [9:0] ad, input logic [7:0] ex);
    point(ad);
    wr(A_CTL, 32'h05);
    rdc(A_BUF, {24'h0, ex});
    rdc(A_CTL, 32'h04);
  endtask : fetch

  task automatic irq_is(input logic ex);
    repeat (2) @(posedge pclk);
    chk_bit("irq", ex, irq);
  endtask : irq_is

  // ****************************************
  // read monitor and timeout
  // ****************************************
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[33]) begin
        chk_bit("pslverr", e[32], pslverr);
        if (!pwrite && !e[32]) chk_data("prdata", e[31:0], prdata);
      end
    end
  end

  // program and fuse space requests, compared in order
  always @(posedge pclk) begin
    if (ext_req.valid === 1'b1) begin
      ext_e = (ext_q.size() > 0) ? ext_q.pop_front() : 22'h0;
      chk_data("ext_req", {10'h0, ext_e}, {10'h0, ext_req});
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    warm_rst_req = 1'b0;
    ext_rdata = 8'h00;
    void'($urandom(74506));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_CTL, 32'h0);
    rdc(A_FLG, 32'h0);
    rdc(A_MSK, 32'h0);
    wr(A_KEY, 32'hFF);
    rdc(A_KEY, 32'h0);
    rdc(12'h01C, 32'h0);
    irq_is(1'b0);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
      d = 8'($urandom);
      wr(A_MSK, {25'h0, i[0], 6'h0});
      prog(a, d, 8'h06);
      wait_done();
      mem[a] = d;
      rdc(A_CTL, 32'h04);
      rdc(A_FLG, 32'h40);
      irq_is(i[0]);
      wr(A_FLG, 32'h40);
      irq_is(1'b0);
      fetch(a, d);
    end
    $display("test write and read done");
    wr(A_CTL, 32'h06);
    rdc(A_CTL, 32'h0C);
    keys();
    wr(A_CTL, 32'h02);
    rdc(A_CTL, 32'h08);
    wr(A_KEY, {24'h0, `NVM_KEY_FIRST});
    wr(A_BUF, 32'h5A);
    wr(A_KEY, {24'h0, `NVM_KEY_SECOND});
    wr(A_CTL, 32'h06);
    rdc(A_CTL, 32'h0C);
    wr(A_CTL, 32'h04);
    rdc(A_FLG, 32'h0);
    fetch(a, mem[a]);
    $display("test refused starts done");
    d = 8'($urandom);
    prog(a, d, 8'h06);
    wr(A_CTL, 32'h0C);
    rdc(A_CTL, 32'h0E);
    wait_done();
    mem[a] = d;
    wr(A_FLG, 32'h40);
    ext_q.push_back({2'b11, 2'h1, a, ~d});
    prog(a, ~d, 8'h86);
    wait_done();
    wr(A_FLG, 32'h40);
    ext_q.push_back({2'b11, 2'h2, a, d});
    prog(a, d, 8'h46);
    wait_done();
    wr(A_FLG, 32'h40);
    fetch(a, d);
    wr(A_CTL, 32'h81);
    rdc(A_CTL, 32'h80);
    ext_b = 8'($urandom);
    ext_rdata <= ext_b;
    ext_q.push_back({2'b10, 2'h2, a, 8'h00});
    wr(A_CTL, 32'h41);
    repeat (2) @(posedge pclk);
    rdc(A_BUF, {24'h0, ext_b});
    rdc(A_CTL, 32'h40);
    $display("test busy and spaces done");
    prog(a, 8'($urandom), 8'h06);
    repeat (3) @(posedge pclk);
    warm_rst_req <= 1'b1;
    repeat (4) @(posedge pclk);
    warm_rst_req <= 1'b0;
    wait_done();
    rdc(A_CTL, 32'h0C);
    rdc(A_FLG, 32'h0);
    chk_data("ext_req left", 32'h0, ext_q.size());
    $display("test warm abort done");
    give_verdict();
  end
endmodule : nvm_access_ctrl_tb_top

`default_nettype wire
